/* core/irq_cfg_pkg.sv */
package irq_cfg_pkg;
  // ----------------------------------------------------------------
  // register offsets (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [11:0] EN_A_OFF = 12'h000;
  localparam logic [11:0] EN_B_OFF = 12'h004;
  localparam logic [11:0] EN_C_OFF = 12'h008;
  localparam logic [11:0] PRIO_T1_OFF = 12'h00C;
  localparam logic [11:0] PRIO_T2_OFF = 12'h010;
  localparam logic [11:0] PRIO_S1_OFF = 12'h014;
  localparam logic [11:0] PRIO_D1_OFF = 12'h018;
  localparam logic [11:0] FLAG_OFF = 12'h01C;
  localparam logic [11:0] MASK_OFF = 12'h020;
  localparam logic [11:0] REQ_OFF = 12'h024;
  // ----------------------------------------------------------------
  // implemented-bit masks of the 16-bit registers
  // ----------------------------------------------------------------
  localparam logic [15:0] EN_A_MASK = 16'hE01E;
  localparam logic [15:0] EN_B_MASK = 16'hC3FF;
  localparam logic [15:0] EN_C_MASK = 16'h003F;
  localparam logic [15:0] PRIO4_MASK = 16'h7777;
  localparam logic [15:0] PRIO2_MASK = 16'h0777;
  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [15:0] EN_RESET = 16'h0000;
  localparam logic [2:0] PRIO_RESET = 3'h4;
  localparam logic [15:0] PRIO4_RESET = 16'h4444;
  localparam logic [15:0] PRIO2_RESET = 16'h0444;
  localparam logic [2:0] PRIO_OFF = 3'h0;
  // ----------------------------------------------------------------
  // source and register counts
  // ----------------------------------------------------------------
  localparam int EN_SRCS = 32;
  localparam int PRIO_SRCS = 15;
  localparam int NUM_REGS = 10;
endpackage

/* core/prio_regfile.sv */
`timescale 1ns/1ps
`default_nettype none
// small register array holding the priority words, registered read data
module prio_regfile
  import irq_cfg_pkg::*;
#(
  parameter int DEPTH = 4,
  parameter int AW = 2
) (
  // clock
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  // write port
  input wire logic we,
  input wire logic [AW-1:0] waddr,
  input wire logic [15:0] wdata,
  input wire logic [15:0] wmask,
  // read port
  input wire logic [AW-1:0] raddr,
  output logic [15:0] rdata,
  // flat view of all words for the request logic
  output logic [DEPTH*16-1:0] words
);
  logic [15:0] mem_q [DEPTH];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < DEPTH; i++) begin
        // the last word carries only three fields
        mem_q[i] <= (i == DEPTH - 1) ? PRIO2_RESET : PRIO4_RESET;
      end
      rdata <= 16'h0000;
    end else if (ce) begin
      if (we) begin
        mem_q[waddr] <= wdata & wmask;
      end
      rdata <= mem_q[raddr];
    end
  end

  always_comb begin
    for (int i = 0; i < DEPTH; i++) begin
      words[i*16 +: 16] = mem_q[i];
    end
  end
endmodule
`default_nettype wire

/* core/irq_cfg_regs.sv */
// The APB register port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// R1 - an enable bit at 1 passes its source's request on, at 0 blocks it.
// R2 - a priority field of 111 gives level 7, the highest.
// R3 - priority code 001 is level 1, codes between map linearly to levels 2 to 6.
// R4 - priority code 000 disables the source whatever its enable bit.
// R5 - at reset every priority field loads 100 and every enable bit clears.
// R6 - unimplemented bits ignore writes and read as 0.
// R7 - each transfer channel completion source owns a 3-bit field at bits 2:0 of its slot.
// R8 - a request reaches the core only with flag set, enable 1 and nonzero priority, carrying its level; the code checks enable or priority, not both.
module irq_cfg_regs
  import irq_cfg_pkg::*;
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // interrupt sources (same clock domain, level flags)
  input wire logic [EN_SRCS-1:0] en_src_flag,
  input wire logic [PRIO_SRCS-1:0] prio_src_flag,
  // gated requests toward core arbitration
  output logic [EN_SRCS-1:0] en_src_req,
  output logic [PRIO_SRCS-1:0] prio_src_req,
  output logic [PRIO_SRCS*3-1:0] prio_src_level,
  output logic [2:0] top_level,
  // summary interrupt
  output logic irq
);
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // field code is the level itself: 001 -> 1 ... 111 -> 7, 000 -> off
  function automatic logic [2:0] prio_level(input logic [2:0] code);
    return code; // see R2 see R3
  endfunction

  function automatic logic prio_active(input logic [2:0] code);
    return code != PRIO_OFF; // see R4
  endfunction

  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------
  // an access completes only in the cycle in which pready stands high
  wire logic acc = psel && penable && pready;
  wire logic setup = psel && !penable;
  wire logic wr = acc && pwrite && clk_en;
  wire logic rd = acc && !pwrite && clk_en;
  wire logic hit_a = paddr == EN_A_OFF;
  wire logic hit_b = paddr == EN_B_OFF;
  wire logic hit_c = paddr == EN_C_OFF;
  wire logic hit_t1 = paddr == PRIO_T1_OFF;
  wire logic hit_t2 = paddr == PRIO_T2_OFF;
  wire logic hit_s1 = paddr == PRIO_S1_OFF;
  wire logic hit_d1 = paddr == PRIO_D1_OFF;
  wire logic hit_flag = paddr == FLAG_OFF;
  wire logic hit_mask = paddr == MASK_OFF;
  wire logic hit_req = paddr == REQ_OFF;
  wire logic hit_prio = hit_t1 || hit_t2 || hit_s1 || hit_d1;
  wire logic mapped = hit_a || hit_b || hit_c || hit_prio || hit_flag || hit_mask || hit_req;
  wire logic [1:0] prio_idx = hit_t1 ? 2'd0 : hit_t2 ? 2'd1 : hit_s1 ? 2'd2 : 2'd3;
  wire logic [15:0] prio_wmask = hit_d1 ? PRIO2_MASK : PRIO4_MASK; // see R6 see R7
  // priority reads wait one cycle for the registered array
  wire logic prio_rd = setup && hit_prio && !pwrite;

  // ----------------------------------------------------------------
  // enable registers
  // ----------------------------------------------------------------
  logic [15:0] en_a_q;
  logic [15:0] en_b_q;
  logic [15:0] en_c_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      en_a_q <= EN_RESET; // see R5
      en_b_q <= EN_RESET;
      en_c_q <= EN_RESET;
    end else if (wr) begin
      if (hit_a) en_a_q <= pwdata[15:0] & EN_A_MASK; // see R6
      if (hit_b) en_b_q <= pwdata[15:0] & EN_B_MASK;
      if (hit_c) en_c_q <= pwdata[15:0] & EN_C_MASK;
    end
  end

  // ----------------------------------------------------------------
  // priority words
  // ----------------------------------------------------------------
  logic [15:0] prio_rdata;
  logic [63:0] prio_words;

  prio_regfile #(
    .DEPTH(4),
    .AW(2)
  ) u_prio (
    .pclk(pclk),
    .presetn(presetn), // see R5
    .ce(clk_en),
    .we(wr && hit_prio),
    .waddr(prio_idx),
    .wdata(pwdata[15:0]),
    .wmask(prio_wmask),
    .raddr(prio_idx),
    .rdata(prio_rdata),
    .words(prio_words)
  );

  // source order: timer, compare, capture, ext per word 0..2 nibbles, then word 3 nibbles 0..2
  logic [2:0] code [PRIO_SRCS];
  always_comb begin
    for (int i = 0; i < PRIO_SRCS; i++) begin
      code[i] = prio_words[(i / 4) * 16 + (i % 4) * 4 +: 3];
    end
  end

  // ----------------------------------------------------------------
  // request gating
  // ----------------------------------------------------------------
  logic [EN_SRCS-1:0] en_req_d;
  logic [PRIO_SRCS-1:0] prio_req_d;
  logic [PRIO_SRCS*3-1:0] prio_lvl_d;
  logic [2:0] top_d;
  always_comb begin
    top_d = 3'h0;
    for (int i = 0; i < PRIO_SRCS; i++) begin
      prio_req_d[i] = prio_src_flag[i] && prio_active(code[i]); // see R4 see R8
      prio_lvl_d[i*3 +: 3] = prio_req_d[i] ? prio_level(code[i]) : 3'h0; // see R8
      if (prio_req_d[i] && prio_level(code[i]) > top_d) top_d = prio_level(code[i]);
    end
  end
  // enable sources: word a packed low, word b above; word c has no flags here
  wire logic [31:0] en_vec = {en_b_q, en_a_q};
  always_comb begin
    for (int i = 0; i < EN_SRCS; i++) begin
      en_req_d[i] = en_src_flag[i] && en_vec[i]; // see R1
    end
  end

  // ----------------------------------------------------------------
  // sticky status, mask and interrupt
  // ----------------------------------------------------------------
  logic [15:0] flag_q;
  logic [15:0] mask_q;
  wire logic [15:0] ev = {1'b0, |en_req_d, prio_req_d[13:0]} | {prio_req_d[14], 15'h0};
  wire logic clr = rd && hit_flag;
  // clear only the bits that the read returned; a new event still wins
  wire logic [15:0] clr_bits = clr ? prdata[15:0] : 16'h0000;
  wire logic [15:0] flag_d = (flag_q & ~clr_bits) | ev;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flag_q <= 16'h0000;
      mask_q <= 16'h0000;
    end else if (clk_en) begin
      flag_q <= flag_d;
      if (wr && hit_mask) mask_q <= pwdata[15:0];
    end
  end

  // ----------------------------------------------------------------
  // output registers
  // ----------------------------------------------------------------
  logic [31:0] rd_d;
  always_comb begin
    rd_d = 32'h0000_0000;
    if (hit_a) rd_d[15:0] = en_a_q;
    if (hit_b) rd_d[15:0] = en_b_q;
    if (hit_c) rd_d[15:0] = en_c_q;
    if (hit_flag) rd_d[15:0] = flag_q;
    if (hit_mask) rd_d[15:0] = mask_q;
    if (hit_req) rd_d[2:0] = top_level;
  end

  // priority reads take the array's registered data one cycle later
  logic prio_rd_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prio_rd_q <= 1'b0;
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
      en_src_req <= '0;
      prio_src_req <= '0;
      prio_src_level <= '0;
      top_level <= 3'h0;
      irq <= 1'b0;
    end else if (clk_en) begin
      en_src_req <= en_req_d;
      prio_src_req <= prio_req_d;
      prio_src_level <= prio_lvl_d;
      top_level <= top_d;
      irq <= |(flag_d & mask_q);
      pready <= (setup && !prio_rd) || prio_rd_q;
      pslverr <= setup && !mapped;
      prio_rd_q <= prio_rd;
      if (setup && !prio_rd) prdata <= rd_d;
      if (prio_rd_q) prdata <= {16'h0000, prio_rdata};
    end
  end
endmodule
`default_nettype wire

/* tb/irq_cfg_props.sv */
`timescale 1ns/1ps
`default_nettype none
module irq_cfg_props
  import irq_cfg_pkg::*;
(
  // clock
  input wire logic pclk,
  input wire logic presetn,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // sources
  input wire logic [EN_SRCS-1:0] en_src_flag,
  input wire logic [PRIO_SRCS-1:0] prio_src_flag,
  input wire logic [EN_SRCS-1:0] en_src_req,
  input wire logic [PRIO_SRCS-1:0] prio_src_req,
  input wire logic [PRIO_SRCS*3-1:0] prio_src_level,
  input wire logic [2:0] top_level
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_en_gate: assert property ((en_src_req & ~$past(en_src_flag)) == '0)
    else $error("enable request without flag");
  a_prio_gate: assert property ((prio_src_req & ~$past(prio_src_flag)) == '0)
    else $error("priority request without flag");
  a_top_idle: assert property (prio_src_req == '0 |-> top_level == 3'd0)
    else $error("top level without request");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  a_ready_setup: assert property (psel && !penable |-> ##[1:2] pready)
    else $error("no ready after setup");
  a_ready_wait: assert property (psel && penable && !pready |=> pready)
    else $error("access wait longer than one cycle");
  a_err_ready: assert property (pslverr |-> pready)
    else $error("error without ready");
  a_read_upper: assert property (pready && !pwrite |-> prdata[31:16] == 16'h0000)
    else $error("upper read bits set");
  for (genvar i = 0; i < PRIO_SRCS; i++) begin : g_src
    a_level_live: assert property (prio_src_req[i] == (prio_src_level[3*i+:3] != 3'd0))
      else $error("level and request disagree");
    a_top_bound: assert property (prio_src_req[i] |-> top_level >= prio_src_level[3*i+:3])
      else $error("top level below a request");
  end
  c_en_req: cover property (en_src_req != '0);
  c_top7: cover property (top_level == 3'd7);
  c_err: cover property (pslverr);
endmodule
bind irq_cfg_regs irq_cfg_props props (.pclk, .presetn, .psel, .penable, .pwrite, .prdata,
  .pready, .pslverr, .en_src_flag, .prio_src_flag, .en_src_req, .prio_src_req,
  .prio_src_level, .top_level);
`default_nettype wire

/* tb/src_model.sv */
`timescale 1ns/1ps
`default_nettype none
module src_model
  import irq_cfg_pkg::*;
(
  // clock
  input wire logic pclk,
  input wire logic presetn,
  // commanded levels
  input wire logic [EN_SRCS-1:0] en_set,
  input wire logic [PRIO_SRCS-1:0] pr_set,
  // flags toward the block
  output logic [EN_SRCS-1:0] en_flag_q,
  output logic [PRIO_SRCS-1:0] pr_flag_q
);
  // sources hold a level flag until told to drop it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      en_flag_q <= '0;
      pr_flag_q <= '0;
    end else begin
      en_flag_q <= en_set;
      pr_flag_q <= pr_set;
    end
  end
endmodule
`default_nettype wire

/* tb/tb.sv */
`timescale 1ns/1ps
`default_nettype none
module tb;
  import irq_cfg_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, er;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [EN_SRCS-1:0] en_set, en_flag, en_src_req;
  logic [PRIO_SRCS-1:0] pr_set, pr_flag, prio_src_req;
  logic [PRIO_SRCS*3-1:0] prio_src_level;
  logic [2:0] top_level;
  logic [11:0] offs [7] = '{EN_A_OFF, EN_B_OFF, EN_C_OFF, PRIO_T1_OFF, PRIO_T2_OFF,
    PRIO_S1_OFF, PRIO_D1_OFF};
  logic [15:0] rv [7] = '{EN_RESET, EN_RESET, EN_RESET, PRIO4_RESET, PRIO4_RESET,
    PRIO4_RESET, PRIO2_RESET};
  logic [15:0] msk [7] = '{EN_A_MASK, EN_B_MASK, EN_C_MASK, PRIO4_MASK, PRIO4_MASK,
    PRIO4_MASK, PRIO2_MASK};
  int error_cnt = 0;
  int cmp_count = 0;
  irq_cfg_regs DUT (.pclk, .presetn, .clk_en(1'b1), .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .en_src_flag(en_flag), .prio_src_flag(pr_flag),
    .en_src_req, .prio_src_req, .prio_src_level, .top_level, .irq);
  src_model partner (.pclk, .presetn, .en_set, .pr_set, .en_flag_q(en_flag),
    .pr_flag_q(pr_flag));
  initial begin
    pclk = 0;
    forever #10 pclk = ~pclk;
  end
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("BAD %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  task automatic settle();
    repeat (3) @(posedge pclk);
    #1;
  endtask
  task automatic t_regs();
    for (int i = 0; i < 7; i++) begin
      apb(1'b0, offs[i], 32'h0000_0000);
      chk("reset value", rd, {16'h0000, rv[i]});
      apb(1'b1, offs[i], 32'hFFFF_FFFF);
      apb(1'b0, offs[i], 32'h0000_0000);
      chk("readback", rd, {16'h0000, msk[i]});
      apb(1'b1, offs[i], 32'h0000_0000);
    end
    apb(1'b0, 12'h0FC, 32'h0000_0000);
    chk("unmapped error", {31'h0, er}, 32'h0000_0001);
    $display("test regs done");
  endtask
  task automatic t_enable();
    apb(1'b1, MASK_OFF, 32'h0000_0000);
    apb(1'b1, EN_A_OFF, 32'h0000_FFFF);
    en_set <= 32'hFFFF_FFFF;
    settle();
    chk("enable gate", en_src_req, {16'h0000, EN_A_MASK});
    chk("masked irq", {31'h0, irq}, 32'h0000_0000);
    apb(1'b1, MASK_OFF, 32'h0000_4000);
    settle();
    chk("unmasked irq", {31'h0, irq}, 32'h0000_0001);
    @(posedge pclk);
    en_set <= 32'h0000_0000;
    apb(1'b0, FLAG_OFF, 32'h0000_0000);
    chk("sticky status", {31'h0, rd[14]}, 32'h0000_0001);
    apb(1'b0, FLAG_OFF, 32'h0000_0000);
    chk("cleared status", {31'h0, rd[14]}, 32'h0000_0000);
    settle();
    chk("irq after clear", {31'h0, irq}, 32'h0000_0000);
    apb(1'b1, EN_A_OFF, 32'h0000_0000);
    en_set <= 32'hFFFF_FFFF;
    settle();
    chk("disabled gate", en_src_req, 32'h0000_0000);
    apb(1'b1, EN_B_OFF, 32'h0000_0001);
    settle();
    chk("word b gate", en_src_req, 32'h0001_0000);
    @(posedge pclk);
    en_set <= 32'h0000_0000;
    $display("test enable done");
  endtask
  task automatic t_prio();
    @(posedge pclk);
    pr_set <= 15'h1000;
    for (int c = 0; c < 8; c++) begin
      apb(1'b1, PRIO_D1_OFF, 32'(c));
      settle();
      chk("prio request", {31'h0, prio_src_req[12]}, 32'(c != 0));
      chk("prio level", {29'h0, prio_src_level[38:36]}, 32'(c));
      chk("top level", {29'h0, top_level}, 32'(c));
    end
    @(posedge pclk);
    pr_set <= 15'h0000;
    settle();
    chk("no request", {17'h0, prio_src_req}, 32'h0000_0000);
    $display("test prio done");
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  initial begin
    presetn = 0;
    {psel, penable, pwrite, paddr, pwdata, en_set, pr_set} = '0;
    repeat (10) @(posedge pclk);
    presetn <= 1;
    t_regs();
    t_enable();
    t_prio();
    conclude();
  end
  initial begin
    repeat (20000) @(posedge pclk);
    error_cnt++;
    conclude();
  end
endmodule
`default_nettype wire
